// ===== pkg/mtc_pkg.sv
package mtc_pkg;
   localparam int TLB_ENTRIES = 48;
   localparam int TLB_IDX_W = 6;
   localparam int CACHE_BYTES = 32768;
   localparam int LINE_BYTES = 32;
   localparam int WAYS = 2;
   localparam int SETS = CACHE_BYTES / LINE_BYTES / WAYS;
   localparam int IDX_W = $clog2(SETS);
   localparam int WORDS = LINE_BYTES / 8;
   localparam int WORD_W = $clog2(WORDS);
   localparam int VPN_W = 27;
   localparam int VPN_W32 = 19;
   localparam int MASK_W = 12;
   localparam int PFN_W = 24;
   // coprocessor register numbers
   localparam logic [4:0] CP_IDENT = 5'h0f;
   localparam logic [4:0] CP_CONFIG = 5'h10;
   localparam logic [4:0] CP_LINKED_LOAD_ADDRESS = 5'h11;
   localparam logic [4:0] CP_CACHE_TAG_LOW = 5'h1c;
   localparam logic [4:0] CP_CACHE_TAG_HIGH = 5'h1d;
   localparam logic [1:0] REG_USER = 2'h0;
   localparam logic [1:0] REG_SUPER = 2'h1;
   localparam logic [1:0] REG_KERNEL = 2'h3;
   localparam logic [2:0] ATTR_WT = 3'h1;
   localparam logic [2:0] ATTR_UNC = 3'h2;
   localparam logic [2:0] ATTR_WB = 3'h3;
   localparam logic [2:0] ATTR_UNC_ACC = 3'h7;
   localparam int CFG_K0_LSB = 0;
   localparam int CFG_BE_BIT = 15;
   localparam int CFG_EM_LSB = 22;
   localparam int CFG_EP_LSB = 24;
   localparam int CFG_EC_LSB = 28;
   localparam logic [31:0] CFG_FIXED_ONE = 32'h0000_0030;
   localparam logic [2:0] CFG_K0_RST = 3'h2;
   localparam logic [3:0] CFG_EP_RST = 4'h0;
   localparam logic [1:0] CFG_EM_RST = 2'h0;
   localparam logic CFG_BE_RST = 1'b0;
   localparam logic [3:0] EP_COMPAT_GAP = 4'h6;
   localparam logic [1:0] SBM_LEGACY = 2'h0;
   localparam int ID_REV_LSB = 0;
   localparam int ID_IMP_LSB = 8;
   localparam logic [31:0] LL_MASK = 32'h0fff_ffff;
   localparam logic [31:0] CACHE_TAG_LOW_MASK = 32'h0fff_fff1;
   localparam logic [23:0] PTAG_MASK = 24'h0f_ffff;
   localparam int TAG_PTAG_LSB = 8;
   localparam int TAG_STATE_LSB = 6;
   localparam int TAG_LOCK_BIT = 5;
   localparam int TAG_LRU_BIT = 4;
   localparam int TAG_PAR_BIT = 0;

   typedef enum logic [1:0] {ST_INVALID = 2'b00, ST_RESERVED = 2'b01,
      ST_CLEAN = 2'b10, ST_DIRTY = 2'b11} mtc_state_e;
   typedef enum logic [1:0] {COP_NONE = 2'b00, COP_STORE_TAG = 2'b01,
      COP_LOAD_TAG = 2'b10} mtc_cop_e;

   typedef struct packed {logic [PFN_W-1:0] pfn; logic [2:0] attr; logic dirty;
      logic valid;} mtc_page_s;
   typedef struct packed {logic [1:0] region; logic [VPN_W-1:0] vpn2; logic [7:0] address_space_identifier;
      logic [MASK_W-1:0] mask; logic global; mtc_page_s even; mtc_page_s odd;}
      mtc_tlb_entry_s;
   typedef struct packed {logic valid; logic [63:0] vaddr; logic [7:0] address_space_identifier;
      logic mode64; logic store; logic unmapped;} mtc_xlat_req_s;
   typedef struct packed {logic valid; logic [35:0] paddr; logic [2:0] attr; logic dirty;
      logic miss; logic invalid; logic modify; logic bypass;} mtc_xlat_rsp_s;
   typedef struct packed {logic [PFN_W-1:0] ptag; mtc_state_e state; logic lock;
      logic parity;} mtc_tag_s;
   typedef struct packed {mtc_cop_e op; logic dside; logic way;
      logic [IDX_W-1:0] index;} mtc_cacheop_s;
   typedef struct packed {logic valid; logic write; logic dside; logic [IDX_W-1:0] index;
      logic [WORD_W-1:0] word; logic [PFN_W-1:0] ptag; logic [2:0] attr;
      logic [63:0] wdata;} mtc_mem_req_s;
   typedef struct packed {logic valid; logic hit; logic parityErr; logic throughWrite;
      logic [63:0] rdata;} mtc_mem_rsp_s;
   typedef struct packed {logic valid; logic dside; logic [IDX_W-1:0] index;
      logic [PFN_W-1:0] ptag;} mtc_refill_s;
   typedef struct packed {logic [3:0] ep; logic [1:0] em; logic be;
      logic [2:0] k0;} mtc_cfg_s;
endpackage

// ===== logic/mtc_mmu_tlb_cache.sv
`timescale 1ns/1ps
module mtc_mmu_tlb_cache
#(
   parameter int TLB_ENTRIES = mtc_pkg::TLB_ENTRIES,
   parameter logic [7:0] IMP_CODE = 8'h5a,  // arbitrary value
   parameter logic [7:0] REV_CODE = 8'h01   // arbitrary value
)
(
   input logic clk,
   input logic arst_n,
   input logic [2:0] strapClkRatio,
   input logic strapCompat,
   input logic cpWrEn,
   input logic cpRdEn,
   input logic [4:0] cpAddr,
   input logic [31:0] cpWrData,
   output logic [31:0] cpRdData,
   input logic llValid,
   input logic [35:0] llPaddr,
   input logic tlbWrEn,
   input logic [mtc_pkg::TLB_IDX_W-1:0] tlbWrIdx,
   input mtc_pkg::mtc_tlb_entry_s tlbWrEntry,
   input logic tlbRdEn,
   input logic [mtc_pkg::TLB_IDX_W-1:0] tlbRdIdx,
   output mtc_pkg::mtc_tlb_entry_s tlbRdEntry,
   input mtc_pkg::mtc_xlat_req_s xlatReq,
   output mtc_pkg::mtc_xlat_rsp_s xlatRsp,
   input mtc_pkg::mtc_cacheop_s cacheOp,
   output logic cacheOpDone,
   input mtc_pkg::mtc_mem_req_s memReq,
   output mtc_pkg::mtc_mem_rsp_s memRsp,
   input mtc_pkg::mtc_refill_s refillReq,
   output logic refillWay,
   output logic refillDenied,
   output logic refillDone,
   input logic refillWordEn,
   input logic [mtc_pkg::WORD_W-1:0] refillWord,
   input logic [63:0] refillData,
   input logic wbActive,
   output logic wbSlot,
   output logic [1:0] sysBusMode,
   output logic bigEndian
);
   import mtc_pkg::*;

   if (TLB_ENTRIES < 1 || TLB_ENTRIES > (1 << TLB_IDX_W))
   begin : gBadCfg
      $error("TLB_ENTRIES out of range");
   end

   function automatic logic tlbMatch(input mtc_tlb_entry_s e, input mtc_xlat_req_s r);
      logic [VPN_W-1:0] diff;
      logic asidOk;
      logic regionOk;
      // the valid bits take no part in the match
      diff = (e.vpn2 ^ r.vaddr[39:13]) & ~{{(VPN_W-MASK_W){1'b0}}, e.mask};
      if (!r.mode64)
         diff[VPN_W-1:VPN_W32] = '0;
      asidOk = e.global || (e.address_space_identifier == r.address_space_identifier);
      regionOk = !r.mode64 || (e.region == r.vaddr[63:62]);
      return (diff == '0) && asidOk && regionOk;
   endfunction

   // returns {words per group, idle cycles}; undefined codes fall back to full rate
   function automatic logic [4:0] wbShape(input logic [3:0] ep, input logic compat);
      logic [4:0] s;
      s = 5'h08;
      if (compat)
      begin
         if (ep == EP_COMPAT_GAP)
            s = 5'h0a;
      end
      else
      begin
         case (ep)
            4'h1: s = 5'h11;
            4'h2: s = 5'h12;
            4'h3: s = 5'h09;
            4'h4: s = 5'h13;
            4'h5: s = 5'h14;
            4'h6: s = 5'h0a;
            4'h7: s = 5'h16;
            4'h8: s = 5'h0b;
            default: s = 5'h08;
         endcase
      end
      return s;
   endfunction

   // straps come from pins: two flops before use
   logic [3:0] strapS1_q;
   logic [3:0] strapS2_q;
   logic compat;
   logic [2:0] clkRatio;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         strapS1_q <= '0;
         strapS2_q <= '0;
      end
      else
      begin
         strapS1_q <= {strapCompat, strapClkRatio};
         strapS2_q <= strapS1_q;
      end
   end
   assign compat = strapS2_q[3];
   assign clkRatio = strapS2_q[2:0];

   // cache arrays
   mtc_tag_s tagMem [2][WAYS][SETS];
   logic lruMem [2][SETS];
   logic [63:0] dataMem [2][WAYS][SETS*WORDS];
   mtc_tag_s opTag;
   logic [31:0] opTagLo;
   mtc_tag_s loTag;

   always_comb
   begin
      opTag = tagMem[cacheOp.dside][cacheOp.way][cacheOp.index];
      opTagLo = '0;
      opTagLo[TAG_PTAG_LSB +: PFN_W] = opTag.ptag & PTAG_MASK;
      opTagLo[TAG_STATE_LSB +: 2] = opTag.state;
      opTagLo[TAG_LOCK_BIT] = opTag.lock;
      opTagLo[TAG_LRU_BIT] = lruMem[cacheOp.dside][cacheOp.index];
      opTagLo[TAG_PAR_BIT] = opTag.parity;
   end

   // coprocessor registers
   mtc_cfg_s cfg_q, cfg_d;
   logic [31:0] linked_load_address_q, linked_load_address_d;
   logic [31:0] cache_tag_low_q, cache_tag_low_d;
   logic [31:0] cache_tag_high_q, cache_tag_high_d;
   logic [31:0] rdData_q, rdData_d;
   logic [31:0] cfgRd;
   logic cacheOpDone_q, cacheOpDone_d;

   always_comb
   begin
      cfgRd = CFG_FIXED_ONE;
      cfgRd[CFG_EC_LSB +: 3] = clkRatio;
      cfgRd[CFG_EP_LSB +: 4] = cfg_q.ep;
      cfgRd[CFG_EM_LSB +: 2] = cfg_q.em;
      cfgRd[CFG_BE_BIT] = cfg_q.be;
      cfgRd[CFG_K0_LSB +: 3] = cfg_q.k0;
      cfg_d = cfg_q;
      linked_load_address_d = linked_load_address_q;
      cache_tag_low_d = cache_tag_low_q;
      cache_tag_high_d = cache_tag_high_q;
      rdData_d = rdData_q;
      cacheOpDone_d = cacheOp.op != COP_NONE;
      if (cpWrEn)
      begin
         case (cpAddr)
            CP_CONFIG:
            begin
               // only writable fields are stored; fixed bits cannot be disturbed
               cfg_d.ep = cpWrData[CFG_EP_LSB +: 4];
               cfg_d.em = cpWrData[CFG_EM_LSB +: 2];
               cfg_d.be = cpWrData[CFG_BE_BIT];
               cfg_d.k0 = cpWrData[CFG_K0_LSB +: 3];
            end
            CP_LINKED_LOAD_ADDRESS: linked_load_address_d = cpWrData & LL_MASK;
            CP_CACHE_TAG_LOW: cache_tag_low_d = cpWrData & CACHE_TAG_LOW_MASK;
            CP_CACHE_TAG_HIGH: cache_tag_high_d = cpWrData;
            default: ;
         endcase
      end
      // hardware capture wins over a same-cycle software write
      if (llValid)
         linked_load_address_d = llPaddr[35:4] & LL_MASK;
      if (cacheOp.op == COP_LOAD_TAG)
         cache_tag_low_d = opTagLo;
      if (cpRdEn)
      begin
         case (cpAddr)
            CP_IDENT:
            begin
               rdData_d = '0;
               rdData_d[ID_REV_LSB +: 8] = REV_CODE;
               rdData_d[ID_IMP_LSB +: 8] = IMP_CODE;
            end
            CP_CONFIG: rdData_d = cfgRd;
            CP_LINKED_LOAD_ADDRESS: rdData_d = linked_load_address_q;
            CP_CACHE_TAG_LOW: rdData_d = cache_tag_low_q;
            CP_CACHE_TAG_HIGH: rdData_d = cache_tag_high_q;
            default: rdData_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_q <= '{ep: CFG_EP_RST, em: CFG_EM_RST, be: CFG_BE_RST, k0: CFG_K0_RST};
         linked_load_address_q <= '0;
         cache_tag_low_q <= '0;
         cache_tag_high_q <= '0;
         rdData_q <= '0;
         cacheOpDone_q <= 1'b0;
      end
      else
      begin
         cfg_q <= cfg_d;
         linked_load_address_q <= linked_load_address_d;
         cache_tag_low_q <= cache_tag_low_d;
         cache_tag_high_q <= cache_tag_high_d;
         rdData_q <= rdData_d;
         cacheOpDone_q <= cacheOpDone_d;
      end
   end
   assign cpRdData = rdData_q;
   assign cacheOpDone = cacheOpDone_q;
   assign bigEndian = cfg_q.be;
   assign sysBusMode = compat ? SBM_LEGACY : cfg_q.em;

   // translation
   mtc_tlb_entry_s tlb_q [TLB_ENTRIES];
   logic [TLB_ENTRIES-1:0] entryHit;
   logic hit;
   logic [TLB_IDX_W-1:0] hitIdx;
   mtc_tlb_entry_s hitEnt;
   mtc_page_s pg;
   logic [12:0] m13, topOne, ext;
   mtc_xlat_rsp_s rsp_q, rsp_d;
   mtc_tlb_entry_s tlbRd_q, tlbRd_d;

   for (genvar g = 0; g < TLB_ENTRIES; g++)
   begin : gMatch
      assign entryHit[g] = tlbMatch(tlb_q[g], xlatReq);
   end

   always_ff @(posedge clk)
   begin
      if (tlbWrEn && int'(tlbWrIdx) < TLB_ENTRIES)
         tlb_q[tlbWrIdx] <= tlbWrEntry;
   end

   always_comb
   begin
      hit = 1'b0;
      hitIdx = '0;
      for (int i = TLB_ENTRIES - 1; i >= 0; i--)
      begin
         if (entryHit[i])
         begin
            hit = 1'b1;
            hitIdx = TLB_IDX_W'(i);
         end
      end
      hitEnt = tlb_q[hitIdx];
      // the top masked bit (vaddr bit 12 when the mask is zero) picks the even or odd page
      m13 = {hitEnt.mask, 1'b1};
      topOne = m13 & ~(m13 >> 1);
      ext = m13 & ~topOne;
      pg = (|(xlatReq.vaddr[24:12] & topOne)) ? hitEnt.odd : hitEnt.even;
      rsp_d = '0;
      rsp_d.valid = xlatReq.valid;
      if (xlatReq.unmapped)
      begin
         rsp_d.paddr = {7'h00, xlatReq.vaddr[28:0]};
         rsp_d.attr = cfg_q.k0;
         rsp_d.dirty = 1'b1;
      end
      else
      begin
         rsp_d.paddr = ({pg.pfn, 12'h000} & ~{11'h000, ext, 12'h000})
            | {11'h000, xlatReq.vaddr[24:12] & ext, xlatReq.vaddr[11:0]};
         rsp_d.attr = pg.attr;
         rsp_d.dirty = pg.dirty;
         rsp_d.miss = xlatReq.valid && !hit;
         rsp_d.invalid = xlatReq.valid && hit && !pg.valid;
         rsp_d.modify = xlatReq.valid && hit && pg.valid && xlatReq.store && !pg.dirty;
      end
      rsp_d.bypass = xlatReq.valid && !rsp_d.miss && rsp_d.attr == ATTR_UNC;
      tlbRd_d = tlbRd_q;
      if (tlbRdEn && int'(tlbRdIdx) < TLB_ENTRIES)
         tlbRd_d = tlb_q[tlbRdIdx];
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rsp_q <= '0;
         tlbRd_q <= '0;
      end
      else
      begin
         rsp_q <= rsp_d;
         tlbRd_q <= tlbRd_d;
      end
   end
   assign xlatRsp = rsp_q;
   assign tlbRdEntry = tlbRd_q;

   // cache pipeline: stage one checks the tag, the edge that ends it writes data
   mtc_mem_req_s s1_q;
   logic [63:0] dataRd_q [WAYS];
   mtc_tag_s t0, t1, r0, r1, tagWrVal;
   logic cacheable, hit0, hit1, anyHit, hitWay;
   logic tagWe, tagWrSide, tagWrWay, lruWe, lruWrSide, lruWrVal, dataWe, dataWrSide;
   logic dataWrWay;
   logic [IDX_W-1:0] tagWrIdx, lruWrIdx;
   logic [IDX_W+WORD_W-1:0] dataWrAddr;
   logic [63:0] dataWrVal;
   logic vicWay, vicDeny;
   logic refWay_q, refWay_d, refDeny_q, refDeny_d, refDone_q, refDone_d;
   logic refSide_q, refSide_d;
   logic [IDX_W-1:0] refIdx_q, refIdx_d;

   always_comb
   begin
      t0 = tagMem[s1_q.dside][0][s1_q.index];
      t1 = tagMem[s1_q.dside][1][s1_q.index];
      cacheable = s1_q.attr != ATTR_UNC && s1_q.attr != ATTR_UNC_ACC;
      hit0 = s1_q.valid && cacheable && t0.state[1] && t0.ptag == (s1_q.ptag & PTAG_MASK);
      hit1 = s1_q.valid && cacheable && t1.state[1] && t1.ptag == (s1_q.ptag & PTAG_MASK);
      anyHit = hit0 || hit1;
      hitWay = hit1;
      memRsp.valid = s1_q.valid;
      memRsp.hit = anyHit;
      memRsp.rdata = dataRd_q[hitWay];
      memRsp.parityErr = anyHit && (hit1 ? ^{t1.ptag, t1.parity} : ^{t0.ptag, t0.parity});
      memRsp.throughWrite = anyHit && s1_q.write && s1_q.attr == ATTR_WT;
      r0 = tagMem[refillReq.dside][0][refillReq.index];
      r1 = tagMem[refillReq.dside][1][refillReq.index];
      vicDeny = r0.lock && r1.lock;
      vicWay = r0.lock ? 1'b1 : (r1.lock ? 1'b0 : lruMem[refillReq.dside][refillReq.index]);
      // single tag write port: diagnostic store, then refill, then dirty marking
      tagWe = 1'b0;
      tagWrSide = s1_q.dside;
      tagWrWay = hitWay;
      tagWrIdx = s1_q.index;
      tagWrVal = hit1 ? t1 : t0;
      tagWrVal.state = ST_DIRTY;
      if (anyHit && s1_q.write && s1_q.attr == ATTR_WB)
         tagWe = 1'b1;
      if (refillReq.valid && !vicDeny)
      begin
         tagWe = 1'b1;
         tagWrSide = refillReq.dside;
         tagWrWay = vicWay;
         tagWrIdx = refillReq.index;
         tagWrVal = '{ptag: refillReq.ptag & PTAG_MASK, state: ST_CLEAN, lock: 1'b0,
            parity: ^(refillReq.ptag & PTAG_MASK)};
      end
      if (cacheOp.op == COP_STORE_TAG)
      begin
         tagWe = 1'b1;
         tagWrSide = cacheOp.dside;
         tagWrWay = cacheOp.way;
         tagWrIdx = cacheOp.index;
         tagWrVal = '{ptag: cache_tag_low_q[TAG_PTAG_LSB +: PFN_W] & PTAG_MASK,
            state: mtc_state_e'(cache_tag_low_q[TAG_STATE_LSB +: 2]),
            lock: cache_tag_low_q[TAG_LOCK_BIT], parity: cache_tag_low_q[TAG_PAR_BIT]};
      end
      // the per-set bit names the way to evict next
      lruWe = anyHit;
      lruWrSide = s1_q.dside;
      lruWrIdx = s1_q.index;
      lruWrVal = !hitWay;
      if (refillReq.valid && !vicDeny)
      begin
         lruWe = 1'b1;
         lruWrSide = refillReq.dside;
         lruWrIdx = refillReq.index;
         lruWrVal = !vicWay;
      end
      if (cacheOp.op == COP_STORE_TAG)
      begin
         lruWe = 1'b1;
         lruWrSide = cacheOp.dside;
         lruWrIdx = cacheOp.index;
         lruWrVal = cache_tag_low_q[TAG_LRU_BIT];
      end
      // refill words take the port; a store hit in the same cycle is dropped
      dataWe = anyHit && s1_q.write;
      dataWrSide = s1_q.dside;
      dataWrWay = hitWay;
      dataWrAddr = {s1_q.index, s1_q.word};
      dataWrVal = s1_q.wdata;
      if (refillWordEn)
      begin
         dataWe = 1'b1;
         dataWrSide = refSide_q;
         dataWrWay = refWay_q;
         dataWrAddr = {refIdx_q, refillWord};
         dataWrVal = refillData;
      end
      refWay_d = refWay_q;
      refDeny_d = refDeny_q;
      refSide_d = refSide_q;
      refIdx_d = refIdx_q;
      refDone_d = refillReq.valid;
      if (refillReq.valid)
      begin
         refWay_d = vicWay;
         refDeny_d = vicDeny;
         refSide_d = refillReq.dside;
         refIdx_d = refillReq.index;
      end
   end

   // a read in the cycle after a store to the same word sees the old data
   always_ff @(posedge clk)
   begin
      for (int w = 0; w < WAYS; w++)
         dataRd_q[w] <= dataMem[memReq.dside][w][{memReq.index, memReq.word}];
      if (dataWe)
         dataMem[dataWrSide][dataWrWay][dataWrAddr] <= dataWrVal;
      if (tagWe)
         tagMem[tagWrSide][tagWrWay][tagWrIdx] <= tagWrVal;
      if (lruWe)
         lruMem[lruWrSide][lruWrIdx] <= lruWrVal;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_q <= '0;
         refWay_q <= 1'b0;
         refDeny_q <= 1'b0;
         refDone_q <= 1'b0;
         refSide_q <= 1'b0;
         refIdx_q <= '0;
      end
      else
      begin
         s1_q <= memReq;
         refWay_q <= refWay_d;
         refDeny_q <= refDeny_d;
         refDone_q <= refDone_d;
         refSide_q <= refSide_d;
         refIdx_q <= refIdx_d;
      end
   end
   assign refillWay = refWay_q;
   assign refillDenied = refDeny_q;
   assign refillDone = refDone_q;

   // write-back cadence
   logic [3:0] wbPos_q, wbPos_d;
   logic [4:0] shape;
   logic [3:0] period;

   always_comb
   begin
      shape = wbShape(cfg_q.ep, compat);
      period = {2'b00, shape[4:3]} + {1'b0, shape[2:0]};
      wbSlot = wbActive && (wbPos_q < {2'b00, shape[4:3]});
      wbPos_d = '0;
      if (wbActive && wbPos_q < period - 4'h1)
         wbPos_d = wbPos_q + 4'h1;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         wbPos_q <= '0;
      else
         wbPos_q <= wbPos_d;
   end
endmodule

// ===== bench/mtc_mmu_tlb_cache_monitor.sv
`timescale 1ns/1ps
module mtc_mmu_tlb_cache_monitor
#(
   parameter logic [7:0] IMP_CODE = 8'h00,
   parameter logic [7:0] REV_CODE = 8'h00
)
(
   input logic clk,
   input logic arst_n,
   input logic strapCompat,
   input logic cpWrEn,
   input logic cpRdEn,
   input logic [4:0] cpAddr,
   input logic [31:0] cpWrData,
   input logic [31:0] cpRdData,
   input mtc_pkg::mtc_xlat_req_s xlatReq,
   input mtc_pkg::mtc_xlat_rsp_s xlatRsp,
   input mtc_pkg::mtc_cacheop_s cacheOp,
   input logic cacheOpDone,
   input mtc_pkg::mtc_mem_req_s memReq,
   input mtc_pkg::mtc_mem_rsp_s memRsp,
   input logic [1:0] sysBusMode,
   input logic bigEndian
);
   import mtc_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   property p_ident;
      cpRdEn && cpAddr == CP_IDENT |=> cpRdData == {16'h0000, IMP_CODE, REV_CODE};
   endproperty
   a_ident: assert property (p_ident) else $error("identity read wrong");
   property p_fixed;
      cpRdEn && cpAddr == CP_CONFIG |=> cpRdData[5:4] == 2'h3;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed config bits wrong");
   property p_topzero;
      cpRdEn && (cpAddr == CP_CACHE_TAG_LOW || cpAddr == CP_LINKED_LOAD_ADDRESS) |=> cpRdData[31:28] == 4'h0;
   endproperty
   a_topzero: assert property (p_topzero) else $error("address top bits set");
   property p_order;
      cpWrEn && cpAddr == CP_CONFIG |=> bigEndian == $past(cpWrData[CFG_BE_BIT]);
   endproperty
   a_order: assert property (p_order) else $error("byte order not taken");
   property p_compat;
      strapCompat [*5] |-> sysBusMode == SBM_LEGACY;
   endproperty
   a_compat: assert property (p_compat) else $error("bus mode not legacy");
   property p_unmap;
      xlatReq.valid && xlatReq.unmapped |=> xlatRsp.valid && !xlatRsp.miss && !xlatRsp.invalid;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access faulted");
   property p_bypass;
      xlatRsp.valid && !xlatRsp.miss && xlatRsp.attr == ATTR_UNC |-> xlatRsp.bypass;
   endproperty
   a_bypass: assert property (p_bypass) else $error("uncached not bypassed");
   property p_memunc;
      memReq.valid && memReq.attr == ATTR_UNC |=> memRsp.valid && !memRsp.hit;
   endproperty
   a_memunc: assert property (p_memunc) else $error("uncached cache hit");
   property p_opdone;
      cacheOp.op != COP_NONE |=> cacheOpDone;
   endproperty
   a_opdone: assert property (p_opdone) else $error("cache op not done");
endmodule
bind mtc_mmu_tlb_cache mtc_mmu_tlb_cache_monitor #(.IMP_CODE(IMP_CODE), .REV_CODE(REV_CODE))
   mon_i (.*);

// ===== bench/mtc_pipe_model.sv
`timescale 1ns/1ps
module mtc_pipe_model
(
   input logic clk,
   output logic cpWrEn,
   output logic cpRdEn,
   output logic [4:0] cpAddr,
   output logic [31:0] cpWrData,
   input logic [31:0] cpRdData
);
   import mtc_pkg::*;
   initial
   begin
      cpWrEn = 1'h0;
      cpRdEn = 1'h0;
      cpAddr = 5'h00;
      cpWrData = 32'h0000_0000;
   end
   task automatic cp_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      cpWrEn <= 1'h1;
      cpAddr <= a;
      cpWrData <= (a == CP_CONFIG) ? (d | CFG_FIXED_ONE) : d;
      @(posedge clk);
      cpWrEn <= 1'h0;
      // released data must not look like a held value
      cpWrData <= ~cpWrData;
   endtask
   task automatic cp_rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      cpRdEn <= 1'h1;
      cpAddr <= a;
      @(posedge clk);
      cpRdEn <= 1'h0;
      #1 d = cpRdData;
   endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import mtc_pkg::*;
   localparam logic [7:0] IMP = 8'h3c;  // arbitrary value
   localparam logic [7:0] REV = 8'h07;  // arbitrary value
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic strapCompat = 1'h0;
   logic [2:0] strapClkRatio = 3'h3;
   logic llValid = 1'h0;
   logic [35:0] llPaddr = '0;
   logic tlbWrEn = 1'h0;
   logic tlbRdEn = 1'h0;
   logic [TLB_IDX_W-1:0] tlbWrIdx = '0;
   logic [TLB_IDX_W-1:0] tlbRdIdx = '0;
   mtc_tlb_entry_s tlbWrEntry = '0;
   mtc_xlat_req_s xlatReq = '0;
   mtc_cacheop_s cacheOp = '0;
   mtc_mem_req_s memReq = '0;
   mtc_refill_s refillReq = '0;
   logic wbActive = 1'h0;
   mtc_tlb_entry_s tlbRdEntry, e0, e1;
   mtc_xlat_rsp_s xlatRsp;
   mtc_mem_rsp_s memRsp;
   logic cpWrEn, cpRdEn, cacheOpDone, bigEndian, wbSlot, refillWay, refillDenied, refillDone;
   logic [4:0] cpAddr;
   logic [31:0] cpWrData, cpRdData, d;
   logic [1:0] sysBusMode;
   int n_mismatch = 0;
   int checks_done = 0;
   mtc_mmu_tlb_cache #(.IMP_CODE(IMP), .REV_CODE(REV)) mtc_mmu_tlb_cache_i (.clk, .arst_n,
      .strapClkRatio, .strapCompat, .cpWrEn, .cpRdEn, .cpAddr, .cpWrData, .cpRdData, .llValid,
      .llPaddr, .tlbWrEn, .tlbWrIdx, .tlbWrEntry, .tlbRdEn, .tlbRdIdx, .tlbRdEntry, .xlatReq,
      .xlatRsp, .cacheOp, .cacheOpDone, .memReq, .memRsp, .refillReq, .refillWay,
      .refillDenied, .refillDone, .refillWordEn(1'h0), .refillWord(2'h0), .refillData('0),
      .wbActive, .wbSlot, .sysBusMode, .bigEndian);
   mtc_pipe_model mtc_pipe_model_i (.clk, .cpWrEn, .cpRdEn, .cpAddr, .cpWrData, .cpRdData);
   always #50 clk = ~clk;
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         n_mismatch++;
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic rd(input logic [4:0] a);
      mtc_pipe_model_i.cp_rd(a, d);
   endtask
   task automatic xl(input logic [63:0] va, input logic [7:0] id, input logic st, input logic um);
      @(posedge clk);
      xlatReq <= '{valid: 1'h1, vaddr: va, address_space_identifier: id, mode64: 1'h1, store: st, unmapped: um};
      @(posedge clk);
      xlatReq.valid <= 1'h0;
      #1;
   endtask
   function automatic logic [63:0] va(input logic [1:0] r, input logic [26:0] v, input logic o);
      return {r, 22'h00_0000, v, o, 12'habc};
   endfunction
   task automatic wb_chk;
      @(posedge clk) wbActive <= 1'h1;
      for (int i = 0; i < 6; i++)
      begin
         #1 chk("wbSlot", i % 3 == 0, wbSlot);
         @(posedge clk);
      end
      wbActive <= 1'h0;
   endtask
   task automatic cop(input mtc_cop_e op, input logic w);
      @(posedge clk);
      cacheOp <= '{op: op, dside: 1'h1, way: w, index: 9'h005};
      @(posedge clk);
      cacheOp.op <= COP_NONE;
      #1 chk("opDone", 1'h1, cacheOpDone);
   endtask
   task t_regs;
      rd(CP_CONFIG);
      chk("cfgReset", 32'h3000_0032, d);
      mtc_pipe_model_i.cp_wr(CP_IDENT, 32'hffff_ffff);
      mtc_pipe_model_i.cp_wr(CP_CONFIG, 32'h7680_8003);
      rd(CP_IDENT);
      chk("ident", {16'h0000, IMP, REV}, d);
      rd(CP_CONFIG);
      chk("cfg", 32'h3680_8033, d);
      chk("bigEndian", 1'h1, bigEndian);
      chk("busMode", 2'h2, sysBusMode);
      wb_chk;
      @(posedge clk) strapCompat <= 1'h1;
      repeat (5) @(posedge clk);
      #1 chk("busModeCompat", 2'h0, sysBusMode);
      wb_chk;
      @(posedge clk) strapCompat <= 1'h0;
      $display("test regs done");
   endtask
   task t_tags;
      mtc_pipe_model_i.cp_wr(CP_CACHE_TAG_LOW, 32'hffff_ffff);
      rd(CP_CACHE_TAG_LOW);
      chk("cache_tag_low", 32'h0fff_fff1, d);
      cop(COP_STORE_TAG, 1'h0);
      mtc_pipe_model_i.cp_wr(CP_CACHE_TAG_LOW, 32'h0000_0000);
      cop(COP_LOAD_TAG, 1'h0);
      rd(CP_CACHE_TAG_LOW);
      chk("tagLoad", 32'h0fff_fff1, d);
      // way 1 unlocked with the set bit pointing at the locked way 0
      mtc_pipe_model_i.cp_wr(CP_CACHE_TAG_LOW, 32'h0000_0000);
      cop(COP_STORE_TAG, 1'h1);
      @(posedge clk) refillReq <= '{1'h1, 1'h1, 9'h005, 24'h00_0123};
      @(posedge clk) refillReq.valid <= 1'h0;
      #1 chk("victim", 3'h5, {refillWay, refillDenied, refillDone});
      mtc_pipe_model_i.cp_wr(CP_CACHE_TAG_HIGH, 32'ha5a5_5a5a);
      rd(CP_CACHE_TAG_HIGH);
      chk("cache_tag_high", 32'ha5a5_5a5a, d);
      @(posedge clk) llValid <= 1'h1;
      llPaddr <= 36'hf_ffff_fff0;
      @(posedge clk) llValid <= 1'h0;
      rd(CP_LINKED_LOAD_ADDRESS);
      chk("linked", 32'h0fff_ffff, d);
      $display("test tags done");
   endtask
   task t_xlat;
      e0 = '{REG_KERNEL, 27'h123_4567, 8'h11, 12'h000, 1'h0, '{24'h00_0abc, ATTR_WB, 1'h1, 1'h1},
         '{24'h00_0def, ATTR_UNC, 1'h0, 1'h1}};
      e1 = e0;
      e1.vpn2 = 27'h000_0042;
      e1.global = 1'h1;
      e1.even.valid = 1'h0;
      @(posedge clk) tlbWrEn <= 1'h1;
      tlbWrEntry <= e0;
      @(posedge clk) tlbWrIdx <= 6'h01;
      tlbWrEntry <= e1;
      @(posedge clk) tlbWrEn <= 1'h0;
      tlbRdEn <= 1'h1;
      @(posedge clk) tlbRdEn <= 1'h0;
      #1 chk("tlbRead", 1'h1, tlbRdEntry === e0);
      xl(va(REG_KERNEL, e0.vpn2, 1'h0), 8'h11, 1'h0, 1'h0);
      chk("hitPa", {24'h00_0abc, 12'habc}, xlatRsp.paddr);
      chk("hit", {ATTR_WB, 5'h10}, xlatRsp[7:0]);
      xl(va(REG_KERNEL, e0.vpn2, 1'h1), 8'h11, 1'h1, 1'h0);
      chk("modify", 4'h3, xlatRsp[3:0]);
      xl(va(REG_KERNEL, e0.vpn2, 1'h0), 8'h22, 1'h0, 1'h0);
      chk("asidMiss", 1'h1, xlatRsp.miss);
      xl(va(REG_SUPER, e0.vpn2, 1'h0), 8'h11, 1'h0, 1'h0);
      chk("regionMiss", 1'h1, xlatRsp.miss);
      xl(va(REG_KERNEL, e1.vpn2, 1'h0), 8'h99, 1'h0, 1'h0);
      chk("globalInv", 2'h1, xlatRsp[3:2]);
      xl(64'h0000_0000_1234_5678, 8'h00, 1'h0, 1'h1);
      chk("unmapped", {ATTR_WB, 36'h0_1234_5678}, {xlatRsp.attr, xlatRsp.paddr});
      @(posedge clk) memReq <= '{1'h1, 1'h0, 1'h1, 9'h005, 2'h0, 24'h00_0000, ATTR_UNC, '0};
      @(posedge clk) memReq.valid <= 1'h0;
      #1 chk("uncHit", 2'h2, {memRsp.valid, memRsp.hit});
      @(posedge clk) memReq <= '{1'h1, 1'h1, 1'h1, 9'h005, 2'h0, 24'h0f_ffff, ATTR_WT, '0};
      @(posedge clk) memReq.valid <= 1'h0;
      #1 chk("wtHit", 4'hf, memRsp[67:64]);
      $display("test xlat done");
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      arst_n <= 1'h1;
      repeat (3) @(posedge clk);
      t_regs;
      t_tags;
      t_xlat;
      report_and_stop;
   end
   initial
   begin
      repeat (2000) @(posedge clk);
      n_mismatch++;
      report_and_stop;
   end
endmodule
